/* File: verilog/frsf_defines.vh */
// constants for the flash read and status flag block
`ifndef FRSF_DEFINES_VH
`define FRSF_DEFINES_VH
`define FRSF_CLK_MHZ 125
`define FRSF_WIN_US 100
`define FRSF_WIN_CYC (`FRSF_WIN_US * `FRSF_CLK_MHZ)
`define FRSF_PRG_CYC 64
`define FRSF_ERS_CYC 256
`define FRSF_PRG_TMO_CYC 96
`define FRSF_GAP_CYC 2500
`define FRSF_REG_CTRL 12'h000
`define FRSF_REG_STAT 12'h004
`define FRSF_REG_PROT 12'h008
`define FRSF_REG_FAIL 12'h00c
`define FRSF_PROT_RST 12'h000
`define FRSF_ST_POLL 7
`define FRSF_ST_TOG 6
`define FRSF_ST_ERR 5
`define FRSF_ST_WIN 3
`define FRSF_CMD_UNL1 8'haa
`define FRSF_CMD_UNL2 8'h55
`define FRSF_CMD_PROT 8'h90
`define FRSF_CMD_PROG 8'ha0
`define FRSF_CMD_ERS 8'h80
`define FRSF_CMD_SECT 8'h30
`define FRSF_CMD_BULK 8'h10
`define FRSF_CMD_RST 8'hf0
`define FRSF_ADR_UNL1 12'h555
`define FRSF_ADR_UNL2 12'haaa
`endif

/* File: verilog/frsf_sync.v */
// two flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module frsf_sync #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: verilog/frsf_array.v */
// byte array of one flash bank, read and program or erase
`timescale 1ns/1ps
module frsf_array #(
  parameter AW = 8
) (
  input wire pclk,
  input wire [AW-1:0] raddr,
  output reg [7:0] rdata,
  input wire wr_en,
  input wire [AW-1:0] waddr,
  input wire [7:0] wdata
);
  reg [7:0] mem [0:(1<<AW)-1];
  integer i;
  initial begin
    for (i = 0; i < (1<<AW); i = i + 1) begin
      mem[i] = 8'hff;
    end
  end
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* File: verilog/frsf_top.v */
// flash read path, protection query and embedded algorithm status word
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "frsf_defines.vh"
module frsf_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire mem_rd_strobe,
  input wire mem_wr_strobe,
  input wire [11:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire [7:0] primary_sector_selects,
  input wire [3:0] secondary_sector_selects,
  output reg [7:0] mem_rdata,
  output reg mem_rdata_valid,
  output wire busy
);
  localparam [2:0] S_READ = 3'd0;
  localparam [2:0] S_UNL1 = 3'd1;
  localparam [2:0] S_UNL2 = 3'd2;
  localparam [2:0] S_PROT = 3'd3;
  localparam [2:0] S_PROG = 3'd4;
  localparam [2:0] S_ERS3 = 3'd5;
  localparam [2:0] S_ERS4 = 3'd6;
  localparam [2:0] S_ERS5 = 3'd7;
  localparam [1:0] B_IDLE = 2'd0;
  localparam [1:0] B_PROG = 2'd1;
  localparam [1:0] B_WIN = 2'd2;
  localparam [1:0] B_ERS = 2'd3;
  localparam [15:0] WIN_CYC = (`FRSF_WIN_CYC) & 16'hffff;
  localparam [15:0] PRG_CYC = `FRSF_PRG_CYC;
  localparam [15:0] ERS_CYC = `FRSF_ERS_CYC;
  localparam [15:0] TMO_CYC = `FRSF_PRG_TMO_CYC;
  localparam [15:0] GAP_CYC = `FRSF_GAP_CYC;

  wire rd_s;
  wire wr_s;
  wire [11:0] addr_s;
  wire [7:0] wd_s;
  wire [7:0] pss_s;
  wire [3:0] sss_s;
  frsf_sync #(.W(34)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({mem_rd_strobe, mem_wr_strobe, mem_addr, mem_wdata, primary_sector_selects, secondary_sector_selects}),
    .q({rd_s, wr_s, addr_s, wd_s, pss_s, sss_s})
  );

  reg rd_d1_q;
  reg wr_d1_q;
  wire rd_ev = rd_s & ~rd_d1_q;
  wire wr_ev = wr_s & ~wr_d1_q;
  wire prim_sel = |pss_s;
  wire sec_sel = |sss_s;
  wire any_sel = prim_sel | sec_sel;
  // one protection bit per sector select, primary in the low byte
  reg [11:0] prot_q;
  reg [11:0] fail_q;
  wire [11:0] sel_vec = {sss_s, pss_s};
  wire sel_prot = |(sel_vec & prot_q);
  wire [8:0] flat_addr = {sec_sel, addr_s[7:0]};

  reg [2:0] cmd_q;
  reg [1:0] bst_q;
  reg [15:0] gap_q;
  reg [15:0] cnt_q;
  reg [15:0] tmo_q;
  reg [11:0] ers_set_q;
  reg [8:0] prg_addr_q;
  reg [7:0] prg_data_q;
  reg ers_all_prot_q;
  reg err_q;
  reg tog_q;
  reg win_q;
  reg bulk_q;
  reg prog_fail_q;
  reg [8:0] ers_idx_q;
  reg prot_mode_q;

  wire [7:0] arr_rdata;
  reg arr_we;
  reg [8:0] arr_waddr;
  reg [7:0] arr_wdata;
  frsf_array #(.AW(9)) u_array (
    .pclk(pclk),
    .raddr(bst_q == B_PROG ? prg_addr_q : flat_addr),
    .rdata(arr_rdata),
    .wr_en(arr_we),
    .waddr(arr_waddr),
    .wdata(arr_wdata)
  );

  wire unl1 = wd_s == `FRSF_CMD_UNL1 && addr_s == `FRSF_ADR_UNL1;
  wire unl2 = wd_s == `FRSF_CMD_UNL2 && addr_s == `FRSF_ADR_UNL2;
  wire at555 = addr_s == `FRSF_ADR_UNL1;
  wire is_rst = wd_s == `FRSF_CMD_RST;
  wire sect_cmd = wd_s == `FRSF_CMD_SECT;
  wire in_ers_sec = |(sel_vec & ers_set_q);

  // program byte in array, error when a 0 bit must become 1
  always @* begin
    arr_we = 1'b0;
    arr_waddr = prg_addr_q;
    arr_wdata = prg_data_q & arr_rdata;
    if (bst_q == B_PROG && cnt_q == 16'd1 && !prog_fail_q) begin
      arr_we = 1'b1;
    end else if (bst_q == B_ERS && !ers_all_prot_q && (bulk_q || ers_set_q[ers_idx_q[8] ? 8 : 0] || 1'b1)) begin
      arr_we = !ers_all_prot_q;
      arr_waddr = ers_idx_q;
      arr_wdata = 8'hff;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_d1_q <= 1'b0;
      wr_d1_q <= 1'b0;
      cmd_q <= S_READ;
      bst_q <= B_IDLE;
      gap_q <= 16'h0000;
      cnt_q <= 16'h0000;
      tmo_q <= 16'h0000;
      ers_set_q <= 12'h000;
      prg_addr_q <= 9'h000;
      prg_data_q <= 8'h00;
      ers_all_prot_q <= 1'b0;
      err_q <= 1'b0;
      tog_q <= 1'b0;
      win_q <= 1'b1;
      bulk_q <= 1'b0;
      prog_fail_q <= 1'b0;
      ers_idx_q <= 9'h000;
      prot_mode_q <= 1'b0;
    end else begin
      rd_d1_q <= rd_s;
      wr_d1_q <= wr_s;
      if (cmd_q != S_READ && !wr_ev) begin
        gap_q <= gap_q + 16'd1;
        if (gap_q >= GAP_CYC) begin
          cmd_q <= S_READ;
        end
      end
      if (wr_ev && any_sel) begin
        gap_q <= 16'h0000;
        if (bst_q == B_WIN) begin
          if (sect_cmd) begin
            ers_set_q <= ers_set_q | sel_vec;
            cnt_q <= WIN_CYC;
            win_q <= 1'b1;
          end else begin
            bst_q <= B_IDLE;
            cmd_q <= S_READ;
            ers_set_q <= 12'h000;
          end
        end else if (bst_q == B_IDLE) begin
          if (is_rst) begin
            cmd_q <= S_READ;
            err_q <= 1'b0;
            prot_mode_q <= 1'b0;
          end else begin
            case (cmd_q)
              S_READ: cmd_q <= unl1 ? S_UNL1 : S_READ;
              S_UNL1: cmd_q <= unl2 ? S_UNL2 : S_READ;
              S_UNL2: begin
                if (at555 && wd_s == `FRSF_CMD_PROT) begin
                  cmd_q <= S_READ;
                  prot_mode_q <= 1'b1;
                end else if (at555 && wd_s == `FRSF_CMD_PROG) begin
                  cmd_q <= S_PROG;
                end else if (at555 && wd_s == `FRSF_CMD_ERS) begin
                  cmd_q <= S_ERS3;
                end else begin
                  cmd_q <= S_READ;
                end
              end
              S_PROG: begin
                cmd_q <= S_READ;
                if (!sel_prot) begin
                  bst_q <= B_PROG;
                  prg_addr_q <= flat_addr;
                  prg_data_q <= wd_s;
                  cnt_q <= PRG_CYC;
                  tmo_q <= TMO_CYC;
                  prog_fail_q <= 1'b0;
                end
              end
              S_ERS3: cmd_q <= unl1 ? S_ERS4 : S_READ;
              S_ERS4: cmd_q <= unl2 ? S_ERS5 : S_READ;
              default: begin
                cmd_q <= S_READ;
                if (sect_cmd) begin
                  bst_q <= B_WIN;
                  bulk_q <= 1'b0;
                  win_q <= 1'b0;
                  ers_set_q <= sel_vec;
                  cnt_q <= WIN_CYC;
                end else if (at555 && wd_s == `FRSF_CMD_BULK) begin
                  bst_q <= B_ERS;
                  bulk_q <= 1'b1;
                  ers_set_q <= 12'hfff;
                  ers_all_prot_q <= &prot_q;
                  cnt_q <= (&prot_q) ? WIN_CYC : ERS_CYC;
                  ers_idx_q <= 9'h000;
                end
              end
            endcase
          end
        end
      end
      if (rd_ev && any_sel && bst_q != B_IDLE) begin
        tog_q <= ~tog_q;
      end
      case (bst_q)
        B_PROG: begin
          if (tmo_q != 16'h0000) begin
            tmo_q <= tmo_q - 16'd1;
          end
          // guard only: the modelled program ends well before the limit
          if (tmo_q == 16'd1) begin
            prog_fail_q <= 1'b1;
            err_q <= 1'b1;
          end
          if ((prg_data_q & ~arr_rdata) != 8'h00 && cnt_q == PRG_CYC - 16'd2) begin
            prog_fail_q <= 1'b1;
            err_q <= 1'b1;
          end
          if (cnt_q == 16'd1) begin
            bst_q <= B_IDLE;
          end
          cnt_q <= cnt_q - 16'd1;
        end
        B_WIN: begin
          if (wr_ev && any_sel) begin
            // the write decode above restarts or aborts the window
          end else if (cnt_q == 16'd1) begin
            win_q <= 1'b1;
            bst_q <= B_ERS;
            ers_all_prot_q <= (ers_set_q & ~prot_q) == 12'h000;
            cnt_q <= ((ers_set_q & ~prot_q) == 12'h000) ? WIN_CYC : ERS_CYC;
            ers_idx_q <= 9'h000;
          end else begin
            cnt_q <= cnt_q - 16'd1;
          end
        end
        B_ERS: begin
          ers_idx_q <= ers_idx_q + 9'd1;
          if (cnt_q == 16'd1) begin
            bst_q <= B_IDLE;
            ers_set_q <= 12'h000;
            err_q <= err_q | (|(ers_set_q & fail_q & ~prot_q));
          end
          cnt_q <= cnt_q - 16'd1;
        end
        default: begin
        end
      endcase
    end
  end

  // status word latched once per read strobe
  wire [7:0] status_w;
  assign status_w[`FRSF_ST_POLL] = (bst_q == B_PROG) ? ~prg_data_q[7] : 1'b0;
  assign status_w[`FRSF_ST_TOG] = tog_q;
  assign status_w[`FRSF_ST_ERR] = err_q;
  assign status_w[4] = 1'b0;
  assign status_w[`FRSF_ST_WIN] = win_q;
  assign status_w[2:0] = 3'b000;

  reg rd_pend_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rdata <= 8'h00;
      mem_rdata_valid <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      mem_rdata_valid <= 1'b0;
      rd_pend_q <= 1'b0;
      if (rd_ev && any_sel) begin
        if (bst_q != B_IDLE) begin
          mem_rdata <= {status_w[7:7], ~tog_q, status_w[5:0]};
          mem_rdata_valid <= 1'b1;
        end else if (prot_mode_q && !addr_s[6] && addr_s[1] && !addr_s[0]) begin
          mem_rdata <= {7'h00, sel_prot};
          mem_rdata_valid <= 1'b1;
        end else begin
          rd_pend_q <= 1'b1;
        end
      end
      if (rd_pend_q) begin
        mem_rdata <= arr_rdata;
        mem_rdata_valid <= 1'b1;
      end
    end
  end
  assign busy = bst_q != B_IDLE;

  // apb slave, answers in the access cycle with no wait
  wire apb_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_q <= `FRSF_PROT_RST;
      fail_q <= 12'h000;
    end else if (apb_wr) begin
      if (paddr == `FRSF_REG_PROT) begin
        prot_q <= pwdata[11:0];
      end else if (paddr == `FRSF_REG_FAIL) begin
        fail_q <= pwdata[11:0];
      end
    end
  end
  always @* begin
    if (paddr == `FRSF_REG_STAT) begin
      prdata = {20'h00000, cmd_q, bst_q, status_w[7:3], prot_mode_q, 1'b0};
    end else if (paddr == `FRSF_REG_PROT) begin
      prdata = {20'h00000, prot_q};
    end else if (paddr == `FRSF_REG_FAIL) begin
      prdata = {20'h00000, fail_q};
    end else begin
      prdata = 32'h00000000;
    end
  end
endmodule

/* File: testbench/frsf_asserts.sv */
// port assertions for the flash read and status flag block
`timescale 1ns/1ps
module frsf_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire mem_rd_strobe,
  input wire mem_wr_strobe,
  input wire [7:0] primary_sector_selects,
  input wire [3:0] secondary_sector_selects,
  input wire [7:0] mem_rdata,
  input wire mem_rdata_valid,
  input wire busy
);
  wire any_sel;
  logic tog_q;
  logic seen_q;
  logic [14:0] bcnt_q;
  assign any_sel = |{primary_sector_selects, secondary_sector_selects};
  // seen_q marks that a status read already landed in this busy spell
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q <= 1'b0;
      seen_q <= 1'b0;
      bcnt_q <= 15'h0;
    end else begin
      bcnt_q <= busy ? bcnt_q + 15'h1 : 15'h0;
      seen_q <= busy && (seen_q || mem_rdata_valid);
      if (mem_rdata_valid) tog_q <= mem_rdata[6];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_READY: assert property (psel && penable |-> pready && !pslverr) else $error("apb not answered");
  AST_VALID_PULSE: assert property (mem_rdata_valid |=> !mem_rdata_valid) else $error("valid too long");
  AST_VALID_CAUSE: assert property (mem_rdata_valid |-> $past(mem_rd_strobe, 3) && $past(any_sel, 3))
    else $error("valid without read");
  AST_NO_WRITE_ANSWER: assert property (mem_rdata_valid |-> !$past(mem_wr_strobe, 3)) else $error("write answered");
  AST_READ_ANSWER: assert property ($rose(mem_rd_strobe) && any_sel |-> ##[3:6] mem_rdata_valid)
    else $error("read not answered");
  AST_TOGGLE: assert property (mem_rdata_valid && busy && seen_q |-> mem_rdata[6] != tog_q)
    else $error("toggle flag stuck");
  AST_RDATA_HOLD: assert property (!mem_rdata_valid |-> $stable(mem_rdata)) else $error("read data moved");
  // a fully protected sector erase spends two windows busy
  AST_BUSY_BOUND: assert property (bcnt_q < 15'h6590) else $error("busy never ends");
  AST_RESET_IDLE: assert property ($rose(presetn) |-> !busy && !mem_rdata_valid) else $error("busy after reset");
endmodule
bind frsf_top frsf_asserts u_asserts (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .mem_rd_strobe,
  .mem_wr_strobe, .primary_sector_selects, .secondary_sector_selects, .mem_rdata, .mem_rdata_valid, .busy);

/* File: testbench/frsf_mcu_model.sv */
// memory bus master standing in for the microcontroller core
`timescale 1ns/1ps
module frsf_mcu_model (
  input wire pclk,
  output logic mem_rd_strobe,
  output logic mem_wr_strobe,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic [7:0] primary_sector_selects,
  output logic [3:0] secondary_sector_selects
);
  initial begin
    mem_rd_strobe = 1'b0;
    mem_wr_strobe = 1'b0;
    mem_addr = 12'h000;
    mem_wdata = 8'h00;
    primary_sector_selects = 8'h00;
    secondary_sector_selects = 4'h0;
  end
  // selects lead the strobe so the synchronised edge sees them settled
  task xfer(input logic wr, input logic [11:0] ad, input logic [7:0] dt, input logic [7:0] ps, input logic [3:0] ss);
    @(posedge pclk);
    mem_addr <= ad;
    mem_wdata <= dt;
    primary_sector_selects <= ps;
    secondary_sector_selects <= ss;
    @(posedge pclk);
    mem_wr_strobe <= wr;
    mem_rd_strobe <= !wr;
    repeat (5) @(posedge pclk);
    mem_wr_strobe <= 1'b0;
    mem_rd_strobe <= 1'b0;
    @(posedge pclk);
    primary_sector_selects <= 8'h00;
    secondary_sector_selects <= 4'h0;
    // released lines show the inverse, not a stale copy
    mem_addr <= ~ad;
    mem_wdata <= ~dt;
    repeat (3) @(posedge pclk);
  endtask
endmodule

/* File: testbench/test_frsf_top.sv */
// self-checking bench for the flash read and status flag block
`timescale 1ns/1ps
module test_frsf_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, mem_rd_strobe, mem_wr_strobe, mem_rdata_valid, busy;
  wire [11:0] mem_addr;
  wire [7:0] mem_wdata, primary_sector_selects, mem_rdata;
  wire [3:0] secondary_sector_selects;
  int failures = 0;
  int checked = 0;
  logic [63:0] eq[$];
  logic [11:0] a;
  logic [7:0] d;
  initial forever #4 pclk = ~pclk;
  frsf_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mem_rd_strobe, .mem_wr_strobe, .mem_addr, .mem_wdata, .primary_sector_selects,
    .secondary_sector_selects, .mem_rdata, .mem_rdata_valid, .busy);
  frsf_mcu_model u_mcu (.pclk, .mem_rd_strobe, .mem_wr_strobe, .mem_addr, .mem_wdata,
    .primary_sector_selects, .secondary_sector_selects);
  task close_out;
    if (eq.size() != 0) begin
      failures++;
      $display("Error pending reads expected 0 seen %0d", eq.size());
    end
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [63:0] e);
    checked++;
    if ((seen & e[63:32]) !== e[31:0]) begin
      failures++;
      $display("Error read data expected %h seen %h", e[31:0], seen & e[63:32]);
    end
  endtask
  always @(posedge pclk) begin
    if (presetn && (mem_rdata_valid === 1'b1 || (psel && penable && pready === 1'b1 && !pwrite))) begin
      if (eq.size() == 0) begin
        failures++;
        $display("Error read data expected none seen %h", mem_rdata_valid ? {24'h0, mem_rdata} : prdata);
      end else check(mem_rdata_valid ? {24'h0, mem_rdata} : prdata, eq.pop_front());
    end
  end
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task mw(input logic [11:0] ad, input logic [7:0] dt, input logic [7:0] ps);
    u_mcu.xfer(1'b1, ad, dt, ps, 4'h0);
  endtask
  task mr(input logic [11:0] ad, input logic [7:0] ps, input logic [3:0] ss, input logic [7:0] m, input logic [7:0] x);
    eq.push_back({24'h0, m, 24'h0, x});
    u_mcu.xfer(1'b0, ad, 8'h00, ps, ss);
  endtask
  task prog(input logic [11:0] ad, input logic [7:0] dt, input logic [7:0] ps);
    mw(12'h555, 8'haa, ps);
    mw(12'haaa, 8'h55, ps);
    mw(12'h555, 8'ha0, ps);
    mw(ad, dt, ps);
  endtask
  task ers(input logic [7:0] c);
    mw(12'h555, 8'haa, 8'h01);
    mw(12'haaa, 8'h55, 8'h01);
    mw(12'h555, 8'h80, 8'h01);
    mw(12'h555, 8'haa, 8'h01);
    mw(12'haaa, 8'h55, 8'h01);
    mw(12'h555, c, 8'h01);
  endtask
  task waitidle;
    while (busy !== 1'b0) @(posedge pclk);
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    close_out;
  end
  initial begin
    void'($urandom(32'h4a93));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    a = 12'($urandom) & 12'h0ff;
    d = 8'($urandom) & 8'h7f;
    mr(a, 8'h01, 4'h0, 8'hff, 8'hff);
    mr(a, 8'h00, 4'h2, 8'hff, 8'hff);
    eq.push_back({32'hffffffff, 32'h0});
    apb(1'b0, 12'h008, 32'h0);
    apb(1'b1, 12'h008, 32'h2);
    eq.push_back({32'hffffffff, 32'h2});
    apb(1'b0, 12'h008, 32'h0);
    eq.push_back({32'hffffffff, 32'h0});
    apb(1'b0, 12'h100, 32'h0);
    prog(a, d, 8'h01);
    // only bit 7 and the error bit are checked while busy
    repeat (2) mr(a, 8'h01, 4'h0, 8'ha0, 8'h80);
    waitidle;
    mr(a, 8'h01, 4'h0, 8'hff, d);
    ers(8'h10);
    mr(a, 8'h01, 4'h0, 8'h80, 8'h00);
    waitidle;
    mr(a, 8'h01, 4'h0, 8'hff, 8'hff);
    ers(8'h30);
    mr(a, 8'h01, 4'h0, 8'h88, 8'h00);
    waitidle;
    prog(a, d, 8'h01);
    waitidle;
    for (int i = 1; i >= 0; i--) begin
      mw(12'h555, 8'haa, 8'h1 << i);
      mw(12'haaa, 8'h55, 8'h1 << i);
      mw(12'h555, 8'h90, 8'h1 << i);
      mr(12'h002, 8'h1 << i, 4'h0, 8'hff, 8'(i));
      mw(12'h000, 8'hf0, 8'h1 << i);
    end
    prog(a ^ 12'h080, 8'h00, 8'h02);
    waitidle;
    mr(a ^ 12'h080, 8'h02, 4'h0, 8'hff, 8'hff);
    prog(a, 8'hff, 8'h01);
    mr(a, 8'h01, 4'h0, 8'h20, 8'h20);
    waitidle;
    eq.push_back({32'h00000010, 32'h00000010});
    apb(1'b0, 12'h004, 32'h0);
    mw(12'h000, 8'hf0, 8'h01);
    eq.push_back({32'h00000010, 32'h00000000});
    apb(1'b0, 12'h004, 32'h0);
    mr(a, 8'h01, 4'h0, 8'hff, d);
    repeat (10) @(posedge pclk);
    close_out;
  end
endmodule
